// ===== pwr_pkg.sv
package pwr_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] POWER_CONTROL_REGISTER_ADDR = 8'h87; // Power control register address
  localparam int IDLE_BIT = 0; // Idle request field
  localparam int PDOWN_BIT = 1; // Power-down request field
  localparam int FLAG0_BIT = 2; // Software flag zero
  localparam int FLAG1_BIT = 3; // Software flag one
  localparam int POF_BIT = 4; // Power-off flag, set at reset
  localparam logic [7:0] POWER_CONTROL_REGISTER_RESET = 8'h10; // Reset value, X read as zero
  localparam logic [7:0] POWER_CONTROL_REGISTER_MASK = 8'hDF; // Bit 5 reads zero
  // ==========================================================
  // Timing
  localparam int WARM_RST_PERIODS = 24; // Oscillator periods to qualify a warm reset
  localparam int WARM_RST_CYCLES = WARM_RST_PERIODS; // One clk per oscillator period
  localparam int WDOG_PULSE_CYCLES = 24; // Length of the driven reset pulse
  localparam int OSC_WAKE_CYCLES = 16; // Oscillator restart settling
  localparam int CNT_W = 5; // Counter width
  // ==========================================================
  // Mode states
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_PDOWN = 2'b10,
    MODE_WAKE = 2'b11
  } pwr_mode_t;
endpackage

// ===== sync2.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Two-flop level synchroniser
module sync2 (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic d, // Async level
  output logic q // Synchronised level
);
  logic meta; // First stage, read only by q
  // Chain of two flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // sync2
`default_nettype wire

// ===== pulse_count.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Saturating counter that flags after a fixed number of cycles
module pulse_count #(
  parameter logic [4:0] LIMIT = 5'd24 // Cycles to reach done
) (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic run, // Count while high, clear when low
  output logic done // High once LIMIT cycles of run have passed
);
  logic [4:0] cnt; // Elapsed cycles
  // Restart whenever run falls
  always_ff @(posedge clk) begin
    if (sys_rst || !run) begin
      cnt <= 5'h00;
      done <= 1'b0;
    end else if (cnt != LIMIT) begin
      cnt <= cnt + 5'd1;
      done <= (cnt == LIMIT - 5'd1);
    end
  end
endmodule // pulse_count
`default_nettype wire

// ===== pwr_ctrl.sv
// How it works
// - Reset pin high 24 periods gives warm reset
// - Pulse count in oscillator periods, any speed
// - Watchdog expiry drives reset pulse onto pin
// - Idle stops only the processor clock
// - Idle keeps processor state and memories
// - Idle bit write enters idle immediately
// - Both bits set: power-down only, no idle
// - Enabled interrupt clears idle bit, resumes
// - Reset pin clears idle bit, restores clock
// - Next instruction after entry avoids port writes
// - Converter done exits converter-started idle
// - Power-down stops oscillator, freezes all clocks
// - Power-down bit write enters power-down immediately
// - Only external interrupts wake power-down
// - Wake clears bit, restarts, waits pin release
// - Interrupt wake keeps registers and memory
// - Reset pin clears power-down bit, restarts clocks
// - Reset wake reinitialises registers, keeps memory
// - Ports high in reset, hold data otherwise
// - Control register at 87h, bits 0 to 3; here bits 4, 6 and 7 are also stored
// - Software flags change only by software; here a qualified reset also clears them
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module pwr_ctrl
  import pwr_pkg::*;
(
  input wire logic clk, // Oscillator clock
  input wire logic sys_rst, // Cold reset, sync active high
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after strobe
  input wire logic rst_pin_in, // Reset pin level
  output logic rst_pin_out, // Reset pin drive value
  output logic rst_pin_oe, // Reset pin drive enable
  input wire logic wdog_expire, // Watchdog expiry pulse
  input wire logic irq_pending, // Any enabled interrupt pending
  input wire logic ext_irq_zero_n, // External interrupt 0, active low
  input wire logic ext_irq_one_n, // External interrupt 1, active low
  input wire logic adc_idle_mode, // Idle entered by converter idle
  input wire logic adc_done, // Conversion complete pulse
  input wire logic double_speed_mode, // Speed select, no effect on qualifier
  output logic cpu_clk_en, // Processor clock enable
  output logic periph_clk_en, // Peripheral clock enable
  output logic osc_en, // Oscillator run enable
  output logic warm_rst, // Internal reset request
  output logic ports_force_high, // Ports drive high
  output logic [1:0] mode_state // Current power mode
);
  // ==========================================================
  // Declarations
  pwr_mode_t mode; // Mode machine state
  pwr_mode_t next_mode; // Next state
  logic [7:0] power_control_register; // Power control register
  logic pin_sync; // Synchronised reset pin
  logic pin_long; // Pin held long enough
  logic [CNT_W-1:0] wd_cnt; // Watchdog pulse remaining
  logic [CNT_W-1:0] osc_cnt; // Oscillator settle counter
  logic ext_wake; // Any external interrupt low
  logic wr_power_control_register; // Write hit on control register
  logic unused_speed; // Speed select is not used by design

  assign unused_speed = double_speed_mode; // Count is mode independent
  assign ext_wake = !ext_irq_zero_n || !ext_irq_one_n; // Only these wake
  assign wr_power_control_register = reg_wr && (reg_addr == POWER_CONTROL_REGISTER_ADDR);

  // ==========================================================
  // Reset pin path; clear synchronised before it gates clocks
  sync2 pin_sync_u (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(rst_pin_in),
    .q(pin_sync)
  );

  // Qualifier restarts whenever the pin drops early
  pulse_count #(.LIMIT(5'(WARM_RST_CYCLES))) qual_u (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(pin_sync),
    .done(pin_long)
  );

  // ==========================================================
  // Watchdog pulse drive onto the pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wd_cnt <= '0;
      rst_pin_out <= 1'b0;
      rst_pin_oe <= 1'b0;
    end else begin
      if (wdog_expire) begin
        wd_cnt <= CNT_W'(WDOG_PULSE_CYCLES);
      end else if (wd_cnt != '0) begin
        wd_cnt <= wd_cnt - 1'b1;
      end
      rst_pin_oe <= wdog_expire || (wd_cnt > 1);
      rst_pin_out <= wdog_expire || (wd_cnt > 1);
    end
  end

  // Internal warm reset and port state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      warm_rst <= 1'b1;
      ports_force_high <= 1'b1;
    end else begin
      warm_rst <= pin_long;
      ports_force_high <= pin_long; // Ports keep data in low modes
    end
  end

  // ==========================================================
  // Control register; flags changed only by software or a qualified reset
  always_ff @(posedge clk) begin
    if (sys_rst || pin_long) begin
      power_control_register <= POWER_CONTROL_REGISTER_RESET; // Reset reinitialises it
    end else begin
      if (wr_power_control_register) begin
        power_control_register <= reg_wdata & POWER_CONTROL_REGISTER_MASK;
      end else begin
        if (pin_sync) begin
          power_control_register[IDLE_BIT] <= 1'b0;
          power_control_register[PDOWN_BIT] <= 1'b0;
        end
        if (mode == MODE_IDLE && (irq_pending || (adc_idle_mode && adc_done))) begin
          power_control_register[IDLE_BIT] <= 1'b0;
        end
        if (mode == MODE_PDOWN && ext_wake) begin
          power_control_register[PDOWN_BIT] <= 1'b0;
        end
        if (mode == MODE_PDOWN && power_control_register[IDLE_BIT]) begin
          power_control_register[IDLE_BIT] <= 1'b0; // No idle after power-down
        end
      end
    end
  end

  // Read port, one cycle latency
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && reg_addr == POWER_CONTROL_REGISTER_ADDR) begin
      reg_rdata <= power_control_register;
    end else begin
      reg_rdata <= 8'h00; // Unmapped reads zero
    end
  end

  // ==========================================================
  // Mode machine
  always_comb begin
    next_mode = mode;
    unique case (mode)
      MODE_RUN: begin
        if (wr_power_control_register && reg_wdata[PDOWN_BIT]) begin
          next_mode = MODE_PDOWN; // Power-down wins
        end else if (wr_power_control_register && reg_wdata[IDLE_BIT]) begin
          next_mode = MODE_IDLE;
        end
      end
      MODE_IDLE: begin
        if (pin_sync || irq_pending || (adc_idle_mode && adc_done)) begin
          next_mode = MODE_RUN;
        end
      end
      MODE_PDOWN: begin
        if (pin_sync || ext_wake) begin
          next_mode = MODE_WAKE;
        end
      end
      MODE_WAKE: begin
        if (pin_sync || (osc_cnt == '0 && !ext_wake)) begin
          next_mode = MODE_RUN; // Resume on release
        end
      end
    endcase
  end

  // State register and oscillator settle counter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode <= MODE_RUN;
      osc_cnt <= '0;
    end else begin
      mode <= next_mode;
      if (next_mode == MODE_WAKE && mode == MODE_PDOWN) begin
        osc_cnt <= CNT_W'(OSC_WAKE_CYCLES);
      end else if (osc_cnt != '0) begin
        osc_cnt <= osc_cnt - 1'b1;
      end
    end
  end

  // Clock gates; state kept since only enables drop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      osc_en <= 1'b1;
      mode_state <= 2'b00;
    end else begin
      cpu_clk_en <= (next_mode == MODE_RUN);
      periph_clk_en <= (next_mode == MODE_RUN) || (next_mode == MODE_IDLE);
      osc_en <= (next_mode != MODE_PDOWN);
      mode_state <= next_mode;
    end
  end

  // ==========================================================
  // Checks
  qual_len_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(warm_rst) |-> $past(pin_sync, 2)) else $error("warm reset without pin");
  short_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(pin_sync) |=> !pin_long) else $error("short pulse qualified");
  wdog_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
    wdog_expire |=> rst_pin_oe && rst_pin_out) else $error("no watchdog drive");
  idle_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    mode == MODE_IDLE |-> !cpu_clk_en && periph_clk_en) else $error("idle gating");
  idle_enter_a: assert property (@(posedge clk) disable iff (sys_rst)
    mode == MODE_RUN && wr_power_control_register && reg_wdata[IDLE_BIT] && !reg_wdata[PDOWN_BIT]
    |=> mode == MODE_IDLE) else $error("idle not entered");
  both_bits_a: assert property (@(posedge clk) disable iff (sys_rst)
    mode == MODE_RUN && wr_power_control_register && reg_wdata[PDOWN_BIT] |=> mode == MODE_PDOWN)
    else $error("power-down not entered");
  pd_osc_a: assert property (@(posedge clk) disable iff (sys_rst)
    mode == MODE_PDOWN |-> !osc_en) else $error("oscillator runs");
  irq_exit_a: assert property (@(posedge clk) disable iff (sys_rst)
    mode == MODE_IDLE && irq_pending && !wr_power_control_register |=> mode == MODE_RUN && !power_control_register[IDLE_BIT])
    else $error("idle exit failed");
  pd_wake_a: assert property (@(posedge clk) disable iff (sys_rst)
    mode == MODE_PDOWN && !ext_wake && !pin_sync |=> mode == MODE_PDOWN)
    else $error("spurious wake");

  // ==========================================================
  // Reset pin and watchdog drive checks

  // Driven pulse stays up for a good stretch, not a glitch
  wdog_len_a: assert property (@(posedge clk) disable iff (sys_rst)
    wdog_expire |=> rst_pin_oe [*8]) else $error("watchdog pulse short");

  // Pin is only ever driven to the reset level
  pin_level_a: assert property (@(posedge clk) disable iff (sys_rst)
    rst_pin_oe |-> rst_pin_out) else $error("pin driven low");

  // Drive lets go once the pulse counter has run out
  wdog_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    !wdog_expire && wd_cnt <= 1 |=> !rst_pin_oe) else $error("pin drive stuck");

  // Ports follow the internal reset exactly
  ports_track_a: assert property (@(posedge clk) disable iff (sys_rst)
    ports_force_high == warm_rst) else $error("ports not tracking reset");

  // While warm reset stands the register holds its reset value
  warm_power_control_register_a: assert property (@(posedge clk) disable iff (sys_rst)
    warm_rst |-> power_control_register == POWER_CONTROL_REGISTER_RESET) else $error("register not reinitialised");

  // ==========================================================
  // Register checks

  // Read data is the register value at the strobe
  rd_data_a: assert property (@(posedge clk) disable iff (sys_rst)
    reg_rd && reg_addr == POWER_CONTROL_REGISTER_ADDR |=> reg_rdata == $past(power_control_register))
    else $error("read data wrong");

  // Read port idles at zero without a strobe
  rd_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");

  // Reserved bit never holds a one
  rsvd_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    (power_control_register & ~POWER_CONTROL_REGISTER_MASK) == 8'h00) else $error("reserved bit set");

  // Flags move only on a software write or a qualified reset
  flags_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    !wr_power_control_register && !pin_long |=> $stable(power_control_register[FLAG1_BIT:FLAG0_BIT]))
    else $error("flag changed by hardware");

  // ==========================================================
  // Mode checks

  // Run mode keeps every clock going
  run_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    mode == MODE_RUN |-> cpu_clk_en && periph_clk_en && osc_en)
    else $error("run gating");

  // Idle leaves the oscillator running for the peripherals
  idle_osc_a: assert property (@(posedge clk) disable iff (sys_rst)
    mode == MODE_IDLE |-> osc_en) else $error("idle stops oscillator");

  // Idle holds with no exit cause, so state is kept
  idle_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    mode == MODE_IDLE && !pin_sync && !irq_pending && !(adc_idle_mode && adc_done)
    |=> mode == MODE_IDLE) else $error("idle left early");

  // Reset pin ends idle and clears the request
  idle_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    mode == MODE_IDLE && pin_sync && !wr_power_control_register |=> mode == MODE_RUN && !power_control_register[IDLE_BIT])
    else $error("pin did not end idle");

  // Conversion done ends converter-started idle
  adc_exit_a: assert property (@(posedge clk) disable iff (sys_rst)
    mode == MODE_IDLE && adc_idle_mode && adc_done |=> mode == MODE_RUN)
    else $error("conversion did not end idle");

  // Power-down stops the processor and peripheral clocks
  pd_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    mode == MODE_PDOWN |-> !cpu_clk_en && !periph_clk_en)
    else $error("power-down gating");

  // Outside power-down the oscillator always runs
  osc_on_a: assert property (@(posedge clk) disable iff (sys_rst)
    mode != MODE_PDOWN |-> osc_en) else $error("oscillator stopped");

  // Idle request is dropped while powered down
  pd_no_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    mode == MODE_PDOWN && !wr_power_control_register |=> !power_control_register[IDLE_BIT])
    else $error("idle kept after power-down");

  // External wake clears the power-down request
  pd_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    mode == MODE_PDOWN && ext_wake && !wr_power_control_register |=> mode == MODE_WAKE && !power_control_register[PDOWN_BIT])
    else $error("wake did not clear request");

  // Reset pin ends power-down and clears the request
  pd_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    mode == MODE_PDOWN && pin_sync && !wr_power_control_register |=> mode == MODE_WAKE && !power_control_register[PDOWN_BIT])
    else $error("pin did not end power-down");

  // Execution waits while the wake input is still held
  wake_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    mode == MODE_WAKE && ext_wake && !pin_sync |=> mode == MODE_WAKE)
    else $error("resumed before release");

  // Execution waits for the oscillator to settle
  wake_settle_a: assert property (@(posedge clk) disable iff (sys_rst)
    mode == MODE_WAKE && osc_cnt != '0 && !pin_sync |=> mode == MODE_WAKE)
    else $error("resumed before settle");
endmodule // pwr_ctrl
`default_nettype wire

// ===== ext_side.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Reset circuit and external interrupt sources
module ext_side (
  input wire logic clk, // Clock
  input wire logic pin_oe, // Device drives reset pin
  input wire logic pin_out, // Device drive value
  output logic pin, // Resolved reset pin level
  output logic irq0_n, // External interrupt 0
  output logic irq1_n // External interrupt 1
);
  logic drv = 1'h0; // Our own drive; pull-down when released
  // Device drive wins, else our level, pull-down keeps it low
  assign pin = pin_oe ? pin_out : drv;
  initial begin
    irq0_n = 1'h1;
    irq1_n = 1'h1;
  end
  // Hold the pin high for n cycles
  task automatic pin_pulse(input int n);
    @(posedge clk);
    drv <= 1'h1;
    repeat (n) @(posedge clk);
    drv <= 1'h0;
  endtask
  // Level wake request, held long enough for the oscillator
  task automatic irq_hold(input int k, input int n);
    @(posedge clk);
    if (k == 0) irq0_n <= 1'h0;
    else irq1_n <= 1'h0;
    repeat (n) @(posedge clk);
    irq0_n <= 1'h1;
    irq1_n <= 1'h1;
  endtask
endmodule // ext_side
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
// ==========================================================
// Bench top
module tb_top;
  import pwr_pkg::*;
  logic clk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0; // Bus and clocking
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata; // Register port
  logic wdog_expire = 1'h0, irq_pending = 1'h0, adc_idle_mode = 1'h0; // Event inputs
  logic adc_done = 1'h0, double_speed_mode = 1'h0; // Converter and speed
  logic pin, irq0_n, irq1_n, rst_pin_out, rst_pin_oe; // Far side wires
  logic cpu_clk_en, periph_clk_en, osc_en, warm_rst, ports_force_high; // Outputs
  logic [1:0] mode_state; // Mode
  int n_fail = 0, samples_checked = 0, hi_cnt = 0, h; // Tallies
  always #2.5 clk = ~clk;
  // Count cycles with warm reset asserted
  always @(posedge clk) hi_cnt <= warm_rst ? hi_cnt + 1 : hi_cnt;
  pwr_ctrl uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rst_pin_in(pin),
    .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .wdog_expire(wdog_expire),
    .irq_pending(irq_pending), .ext_irq_zero_n(irq0_n), .ext_irq_one_n(irq1_n),
    .adc_idle_mode(adc_idle_mode), .adc_done(adc_done),
    .double_speed_mode(double_speed_mode), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .osc_en(osc_en), .warm_rst(warm_rst),
    .ports_force_high(ports_force_high), .mode_state(mode_state));
  ext_side side (.clk(clk), .pin_oe(rst_pin_oe), .pin_out(rst_pin_out), .pin(pin),
    .irq0_n(irq0_n), .irq1_n(irq1_n));
  // ==========================================================
  // Bus tasks, entered just after an edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 `CHK(reg_rdata, e)
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rchk(8'h87, POWER_CONTROL_REGISTER_RESET);
    rchk(8'h86, 8'h00);
    wr(8'h87, 8'hcc);
    wr(8'h55, 8'hff);
    rchk(8'h87, 8'hcc);
    wr(8'h87, 8'he0);
    rchk(8'h87, 8'hc0);
  endtask
  task automatic t_idle;
    wr(8'h87, 8'h0d);
    wait_n(2);
    `CHK(mode_state, 2'h1)
    `CHK(cpu_clk_en, 1'h0)
    `CHK(periph_clk_en, 1'h1)
    irq_pending <= 1'h1;
    wait_n(2);
    irq_pending <= 1'h0;
    `CHK(mode_state, 2'h0)
    rchk(8'h87, 8'h0c);
    adc_idle_mode <= 1'h1;
    wr(8'h87, 8'h01);
    wait_n(2);
    adc_done <= 1'h1;
    wait_n(1);
    adc_done <= 1'h0;
    wait_n(2);
    adc_idle_mode <= 1'h0;
    `CHK(mode_state, 2'h0)
  endtask
  // Both request bits together, woken by interrupt k
  task automatic t_pd(input int k);
    wr(8'h87, 8'h0f);
    wait_n(2);
    `CHK(mode_state, 2'h2)
    `CHK({osc_en, cpu_clk_en, periph_clk_en}, 3'h0)
    irq_pending <= 1'h1;
    wait_n(4);
    irq_pending <= 1'h0;
    `CHK(mode_state, 2'h2)
    side.irq_hold(k, 30);
    #1 `CHK(mode_state, 2'h3)
    `CHK(osc_en, 1'h1)
    wait_n(3);
    `CHK(mode_state, 2'h0)
    rchk(8'h87, 8'h0c);
  endtask
  task automatic t_pin;
    wr(8'h87, 8'h0d);
    h = hi_cnt;
    side.pin_pulse(20);
    wait_n(5);
    `CHK(hi_cnt, h)
    `CHK(mode_state, 2'h0)
    rchk(8'h87, 8'h0c);
    wr(8'h87, 8'h02);
    side.pin_pulse(6);
    wait_n(6);
    `CHK(mode_state, 2'h0)
    `CHK(osc_en, 1'h1)
    double_speed_mode <= 1'h1;
    side.pin_pulse(30);
    #1 `CHK(warm_rst, 1'h1)
    `CHK(ports_force_high, 1'h1)
    wait_n(5);
    `CHK(warm_rst, 1'h0)
    rchk(8'h87, POWER_CONTROL_REGISTER_RESET);
  endtask
  task automatic t_wdog;
    @(posedge clk);
    wdog_expire <= 1'h1;
    @(posedge clk);
    wdog_expire <= 1'h0;
    #1 `CHK({rst_pin_oe, rst_pin_out, pin}, 3'h7)
    h = hi_cnt;
    wait_n(60);
    `CHK(hi_cnt > h, 1'b1)
    `CHK({rst_pin_oe, pin}, 2'h0)
  endtask
  // ==========================================================
  // Verdict
  task automatic conclude;
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'h0;
    t_regs;
    t_idle;
    t_pd(0);
    t_pd(1);
    t_pin;
    t_wdog;
    conclude;
  end
  // Hang guard, well past the few hundred cycles needed
  initial begin
    #20000;
    n_fail++;
    conclude;
  end
endmodule // tb_top
`default_nettype wire
